// ### verilog/ebw_wait_bank.sv
// Wait-state generator and bank-switch sequencer with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Stretch bus cycles up to fourteen wait states
// - Every external access gets at least one wait
// - Selected subsystem's wait register governs the bus
// - Low bits hold five 3-bit base counts
// - Reset gives seven waits, multiplier cleared
// - Bits 14-12 time all I/O accesses
// - Bits 11-9 time upper data accesses
// - Bits 8-6 time lower data accesses
// - Bits 5-3 time upper program unless extended
// - Bits 2-0 time lower or all program
// - Bit 15 selects extended program range, resets 0
// - Multiplier bit doubles the base count
// - Multiplier bit 0; upper bits read zero
// - Idle cycle on bank crossing within program or data space
// - Idle cycle program-to-data or program page change
// - Selected subsystem's bank register sets bank size
// - Four-bit mask picks compared address MSBs
// - Optional idle cycle between program/data reads
// - Bus-off idles bus after current cycle
module ebw_wait_bank
   import ebw_pkg::*;
#(
   parameter int ADDR_WIDTH = 12
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // AXI4-Lite register slave
   input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Subsystem select pin, asynchronous
   input wire logic subsystem_select,
   // CPU access request
   input wire logic acc_valid,
   output logic acc_ready,
   input wire logic [1:0] acc_space,
   input wire logic acc_read,
   input wire logic [17:0] acc_addr,
   output logic acc_done,
   // External bus
   output logic ext_strobe,
   output logic ext_idle,
   output logic [17:0] ext_addr,
   output logic [1:0] ext_space,
   output logic ext_drive_enable,
   output logic bus_hold_enable
);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Refused at elaboration: the decode needs address bits 9:2
   if (ADDR_WIDTH < 10) begin : g_addr_check
      $error("ADDR_WIDTH must cover both register sets");
   end

   // ------------------------------------------------------------
   // Register sets, index 0 subsystem A, index 1 subsystem B
   // ------------------------------------------------------------
   logic [15:0] wait_cfg [2];   // ext_wait_config
   logic [15:0] mult_ctrl [2];  // wait_multiplier_control
   logic [15:0] bank_ctrl [2];  // bank_switch_control
   logic sel_meta;              // First synchroniser stage
   logic sel_sync;              // Selected subsystem, clock domain
   logic aw_held;               // Write address captured
   logic [ADDR_WIDTH-1:0] aw_addr;
   logic w_held;                // Write data captured
   logic [15:0] w_data;
   logic [1:0] w_strb;
   logic do_write;              // Both halves present, response free
   logic wr_hit;                // Write address is mapped
   logic [15:0] rd_value;
   logic rd_hit;

   // Register lookup by byte address
   function automatic logic [15:0] reg_value(
      input logic [ADDR_WIDTH-1:0] addr,
      input logic [15:0] wc [2],
      input logic [15:0] mc [2],
      input logic [15:0] bc [2],
      output logic hit);
      logic sub;
      logic [6:0] idx;
      logic [15:0] value;
      sub = addr[SUB_B_ADDR_BIT];
      idx = addr[8:2];
      value = 16'h0000;
      hit = (addr[1:0] == 2'h0) && (addr >> 10 == 0);
      case (idx)
         WAIT_CONFIG_IDX: value = wc[sub];
         MULT_CTRL_IDX: value = mc[sub];
         BANK_CTRL_IDX: value = bc[sub];
         default: hit = 1'b0;
      endcase
      return value;
   endfunction

   // Merge strobed bytes into writable bits only
   function automatic logic [15:0] merge(
      input logic [15:0] old,
      input logic [15:0] data,
      input logic [1:0] strb,
      input logic [15:0] wmask);
      logic [15:0] lanes;
      lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
      return (old & ~lanes) | (data & lanes);
   endfunction

   // Pin passes two flip-flops before use
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sel_meta <= 1'b0;
         sel_sync <= 1'b0;
      end else begin
         sel_meta <= subsystem_select;
         sel_sync <= sel_meta;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------
   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   // Address and data are taken in either order
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         w_held <= 1'b0;
         w_data <= 16'h0000;
         w_strb <= 2'h0;
      end else begin
         if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata[15:0];
            w_strb <= s_axi_wstrb[1:0];
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   // Write response one cycle after both halves are held
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Register update; unmapped writes change nothing
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 2; i++) begin
            wait_cfg[i] <= WAIT_CONFIG_RESET;
            mult_ctrl[i] <= MULT_CTRL_RESET;
            bank_ctrl[i] <= BANK_CTRL_RESET;
         end
      end else if (do_write && wr_hit) begin
         case (aw_addr[8:2])
            WAIT_CONFIG_IDX: wait_cfg[aw_addr[SUB_B_ADDR_BIT]] <= merge(
               wait_cfg[aw_addr[SUB_B_ADDR_BIT]], w_data, w_strb,
               WAIT_CONFIG_WMASK);
            MULT_CTRL_IDX: mult_ctrl[aw_addr[SUB_B_ADDR_BIT]] <= merge(
               mult_ctrl[aw_addr[SUB_B_ADDR_BIT]], w_data, w_strb,
               MULT_CTRL_WMASK);
            BANK_CTRL_IDX: bank_ctrl[aw_addr[SUB_B_ADDR_BIT]] <= merge(
               bank_ctrl[aw_addr[SUB_B_ADDR_BIT]], w_data, w_strb,
               BANK_CTRL_WMASK);
            default: ;
         endcase
      end
   end

   // Decode hits for both channels
   always_comb begin
      void'(reg_value(aw_addr, wait_cfg, mult_ctrl, bank_ctrl, wr_hit));
      rd_value = reg_value(s_axi_araddr, wait_cfg, mult_ctrl, bank_ctrl,
         rd_hit);
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;

   // Read data one cycle after the address; upper bits read zero
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {16'h0000, rd_value};
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Active configuration and wait count
   // ------------------------------------------------------------
   logic [15:0] cfg_wait;      // Governing set, chosen by the pin
   logic [15:0] cfg_bank;
   logic cfg_double;
   logic [2:0] base;
   logic [3:0] next_count;
   logic need_gap;
   logic take;
   ebw_state_type state;
   logic [3:0] pend_count;     // Count kept across an idle cycle
   logic prev_valid;           // An earlier access exists
   logic [1:0] prev_space;
   logic prev_read;
   logic [17:0] prev_addr;
   logic off_active;           // Bus released
   logic [3:0] bank_mask;

   assign cfg_wait = wait_cfg[sel_sync];
   assign cfg_bank = bank_ctrl[sel_sync];
   assign cfg_double = mult_ctrl[sel_sync][DOUBLE_BIT];
   assign bank_mask = cfg_bank[MASK_LSB +: 4];
   assign bus_hold_enable = cfg_bank[HOLD_BIT];

   // Range decode picks one base count
   always_comb begin
      case (acc_space)
         SPACE_IO: base = cfg_wait[IO_LSB +: BASE_WIDTH];
         SPACE_DATA: begin
            if (acc_addr[15]) begin
               base = cfg_wait[DATA_HI_LSB +: BASE_WIDTH];
            end else begin
               base = cfg_wait[DATA_LO_LSB +: BASE_WIDTH];
            end
         end
         default: begin
            if (!cfg_wait[EXT_PROG_BIT] && acc_addr[15]) begin
               base = cfg_wait[PROG_HI_LSB +: BASE_WIDTH];
            end else begin
               base = cfg_wait[PROG_LO_LSB +: BASE_WIDTH];
            end
         end
      endcase
   end

   // Doubling gives at most fourteen; zero is raised to one
   always_comb begin
      next_count = cfg_double ? {base, 1'b0} : {1'b0, base};
      if (next_count == 4'h0) begin
         next_count = MIN_WAIT;
      end
   end

   // Turnaround idle cycle decision against the previous access
   always_comb begin
      logic same_mem;
      logic bank_cross;
      logic page_cross;
      logic space_cross;
      logic read_turn;
      same_mem = (acc_space == prev_space) && (acc_space != SPACE_IO);
      bank_cross = same_mem && ((acc_addr[15:12] & bank_mask) !=
         (prev_addr[15:12] & bank_mask));
      page_cross = (acc_space == SPACE_PROG) && same_mem &&
         (acc_addr[17:16] != prev_addr[17:16]);
      space_cross = (prev_space == SPACE_PROG) &&
         (acc_space == SPACE_DATA);
      read_turn = cfg_bank[TURN_BIT] && acc_read && prev_read &&
         (((prev_space == SPACE_PROG) && (acc_space == SPACE_DATA)) ||
         ((prev_space == SPACE_DATA) && (acc_space == SPACE_PROG)));
      need_gap = prev_valid &&
         (bank_cross || page_cross || space_cross || read_turn);
   end

   // ------------------------------------------------------------
   // Access sequencer
   // ------------------------------------------------------------
   ebw_timing_if tif ();

   ebw_wait_timer #(
      .COUNT_WIDTH(4)
   ) u_timer (
      .clock(clock),
      .rst(rst),
      .tif(tif)
   );

   // New access only when idle and the bus is not switched off
   assign acc_ready = (state == ST_IDLE) && !off_active &&
      !cfg_bank[OFF_BIT];
   assign take = acc_valid && acc_ready;
   assign tif.start = (take && !need_gap) || (state == ST_GAP);
   assign tif.wait_count = (state == ST_GAP) ? pend_count : next_count;
   assign acc_done = tif.done;

   // State: idle, optional turnaround cycle, wait cycles
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (take) begin
                  state <= need_gap ? ST_GAP : ST_WAIT;
               end
            end
            ST_GAP: state <= ST_WAIT;  // One idle cycle only
            ST_WAIT: begin
               if (tif.done) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Remember the access for the next turnaround decision
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prev_valid <= 1'b0;
         prev_space <= SPACE_PROG;
         prev_read <= 1'b0;
         prev_addr <= 18'h00000;
         pend_count <= MIN_WAIT;
      end else if (take) begin
         prev_valid <= 1'b1;
         prev_space <= acc_space;
         prev_read <= acc_read;
         prev_addr <= acc_addr;
         pend_count <= next_count;
      end
   end

   // External bus outputs, registered
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ext_strobe <= 1'b0;
         ext_idle <= 1'b0;
         ext_addr <= 18'h00000;
         ext_space <= SPACE_PROG;
      end else begin
         ext_idle <= take && need_gap;
         if (tif.start) begin
            ext_strobe <= 1'b1;
         end else if (tif.done) begin
            ext_strobe <= 1'b0;
         end
         if (take) begin
            ext_addr <= acc_addr;
            ext_space <= acc_space;
         end
      end
   end

   // Bus-off takes effect only between bus cycles
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         off_active <= 1'b0;
      end else if (state == ST_IDLE && !take) begin
         off_active <= cfg_bank[OFF_BIT];
      end
   end
   assign ext_drive_enable = !off_active;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_wait_at_least: assert property (
      @(posedge clock) disable iff (rst)
      tif.start |-> (tif.wait_count >= MIN_WAIT))
      else $error("bus cycle started with no wait state");

   a_wait_ceiling: assert property (
      @(posedge clock) disable iff (rst)
      tif.start |-> (tif.wait_count <= MAX_WAIT))
      else $error("wait count above fourteen");

   a_reset_seven_waits: assert property (
      @(posedge clock)
      $past(rst) |-> (wait_cfg[0] == WAIT_CONFIG_RESET) &&
         (mult_ctrl[1] == MULT_CTRL_RESET))
      else $error("registers not at reset value after reset");

   a_mult_reserved_zero: assert property (
      @(posedge clock) disable iff (rst)
      (mult_ctrl[0][15:1] == 15'h0000) && (mult_ctrl[1][15:1] == 15'h0000))
      else $error("multiplier register reserved bits not zero");

   a_io_count_double: assert property (
      @(posedge clock) disable iff (rst)
      take && !need_gap && acc_space == SPACE_IO && cfg_double &&
      cfg_wait[IO_LSB +: 3] != 3'h0 |->
      tif.wait_count == {cfg_wait[IO_LSB +: 3], 1'b0})
      else $error("I/O count not doubled");

   a_gap_one_cycle: assert property (
      @(posedge clock) disable iff (rst)
      take && need_gap |=> (state == ST_GAP) ##1 (state == ST_WAIT))
      else $error("turnaround is not exactly one idle cycle");

   a_read_turnaround: assert property (
      @(posedge clock) disable iff (rst)
      take && prev_valid && cfg_bank[TURN_BIT] && acc_read && prev_read &&
      prev_space == SPACE_DATA && acc_space == SPACE_PROG |=>
      state == ST_GAP)
      else $error("no idle cycle between data and program reads");

   a_bus_off_idle: assert property (
      @(posedge clock) disable iff (rst)
      state == ST_IDLE && !take && cfg_bank[OFF_BIT] |=>
      !ext_drive_enable && !acc_ready)
      else $error("bus not released when switched off");

   a_done_ends_strobe: assert property (
      @(posedge clock) disable iff (rst)
      tif.done |=> !ext_strobe && state == ST_IDLE)
      else $error("bus cycle did not complete after last wait");

endmodule
`default_nettype wire

// ### verilog/ebw_pkg.sv
// Constants and types shared by the wait-state and bank-switch block
package ebw_pkg;

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [6:0] WAIT_CONFIG_IDX = 7'h28;  // ext_wait_config
   localparam logic [6:0] MULT_CTRL_IDX = 7'h2b;  // wait_multiplier_control
   localparam logic [6:0] BANK_CTRL_IDX = 7'h29;  // bank_switch_control
   localparam int SUB_B_ADDR_BIT = 9;  // Byte address bit picking set B

   // ------------------------------------------------------------
   // Reset values and writable bit masks
   // ------------------------------------------------------------
   localparam logic [15:0] WAIT_CONFIG_RESET = 16'h7fff;
   localparam logic [15:0] MULT_CTRL_RESET = 16'h0000;
   localparam logic [15:0] BANK_CTRL_RESET = 16'hf800;
   localparam logic [15:0] WAIT_CONFIG_WMASK = 16'hffff;
   localparam logic [15:0] MULT_CTRL_WMASK = 16'h0001;
   localparam logic [15:0] BANK_CTRL_WMASK = 16'hf805;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int EXT_PROG_BIT = 15; // extended_prog_range_select
   localparam int IO_LSB = 12;       // I/O base count
   localparam int DATA_HI_LSB = 9;   // Upper data base count
   localparam int DATA_LO_LSB = 6;   // Lower data base count
   localparam int PROG_HI_LSB = 3;   // Upper program base count
   localparam int PROG_LO_LSB = 0;   // Program base count
   localparam int BASE_WIDTH = 3;    // Width of one base count
   localparam int DOUBLE_BIT = 0;    // wait_double_select
   localparam int MASK_LSB = 12;     // bank_compare_mask
   localparam int TURN_BIT = 11;     // read_turnaround_enable
   localparam int HOLD_BIT = 2;      // Bus holder enable
   localparam int OFF_BIT = 0;       // ext_bus_off

   // ------------------------------------------------------------
   // Counts, space codes, bus answers
   // ------------------------------------------------------------
   localparam logic [3:0] MAX_WAIT = 4'he;   // Doubled 7
   localparam logic [3:0] MIN_WAIT = 4'h1;
   localparam logic [1:0] SPACE_PROG = 2'h0;
   localparam logic [1:0] SPACE_DATA = 2'h1;
   localparam logic [1:0] SPACE_IO = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Access sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_GAP, ST_WAIT} ebw_state_type;

endpackage

// ### verilog/ebw_timing_if.sv
// Interface between the access sequencer and the wait-state timer
`timescale 1ns/1ps
`default_nettype none
interface ebw_timing_if;
   logic start;             // One-cycle pulse: begin a bus cycle
   logic [3:0] wait_count;  // Wait cycles for that bus cycle
   logic done;              // One-cycle pulse: last wait cycle
   logic busy;              // Timer is counting

   modport ctrl (output start, output wait_count, input done, input busy);
   modport timer (input start, input wait_count, output done, output busy);
endinterface
`default_nettype wire

// ### verilog/ebw_wait_timer.sv
// Wait-state down counter that holds one external bus cycle
`timescale 1ns/1ps
`default_nettype none
module ebw_wait_timer
   import ebw_pkg::*;
#(
   parameter int COUNT_WIDTH = 4
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Sequencer side
   ebw_timing_if.timer tif
);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Refused at elaboration: the sequencer hands over four bits
   if (COUNT_WIDTH != 4) begin : g_width_check
      $error("COUNT_WIDTH must match the 4-bit wait count");
   end

   logic [COUNT_WIDTH-1:0] remaining;  // Wait cycles still to run
   logic [COUNT_WIDTH-1:0] loaded;     // Count of the current cycle
   logic [COUNT_WIDTH-1:0] elapsed;    // Helper for the timing check

   // Busy from start until the last wait cycle
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tif.busy <= 1'b0;
      end else if (tif.start) begin
         tif.busy <= 1'b1;
      end else if (tif.done) begin
         tif.busy <= 1'b0;
      end
   end

   // Down counter; the sequencer never starts while busy
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         remaining <= '0;
      end else if (tif.start) begin
         remaining <= tif.wait_count;
      end else if (tif.busy) begin
         remaining <= remaining - 1'b1;
      end
   end

   // Last wait cycle ends the access
   assign tif.done = tif.busy && (remaining == 4'h1);

   // Helper: cycles spent in the current bus cycle
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         elapsed <= '0;
         loaded <= '0;
      end else if (tif.start) begin
         elapsed <= 4'h1;
         loaded <= tif.wait_count;
      end else if (tif.busy) begin
         elapsed <= elapsed + 1'b1;
      end
   end

   a_done_after_count: assert property (
      @(posedge clock) disable iff (rst)
      tif.done |-> (elapsed == loaded))
      else $error("bus cycle did not last its wait count");

endmodule
`default_nettype wire

// ### bench/ebw_ext_dev.sv
// Model of the slow external device that watches each bus cycle
`timescale 1ns/1ps
`default_nettype none
module ebw_ext_dev (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Bus cycle marks from the block
   input wire logic ext_strobe,
   input wire logic ext_idle,
   // Wait cycles of the last bus cycle, idle cycles seen so far
   output logic [4:0] waits,
   output var int idles
);
   logic was_on;  // Strobe seen in the cycle before
   // A rising strobe opens a new cycle; it only gets longer while held
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         waits <= 5'h0;
         was_on <= 1'h0;
         idles <= 0;
      end else begin
         was_on <= ext_strobe;
         if (ext_strobe)
            waits <= was_on ? waits + 5'h1 : 5'h1;
         if (ext_idle)
            idles <= idles + 1;
      end
   end
endmodule
`default_nettype wire

// ### bench/tb.sv
// Bench: registers over AXI4-Lite, then timed external accesses
`timescale 1ns/1ps
`default_nettype none
`define CK(g, e) begin checks++; if (64'(g) !== 64'(e)) begin failures++; \
$display("Error %0t got %h exp %h", $time, 64'(g), 64'(e)); end end
module tb;
   // Inputs, all settled at time zero
   logic clock = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic subsystem_select = 0, acc_valid = 0, acc_read = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h3;
   logic [1:0] acc_space = 0, s_axi_bresp, s_axi_rresp, ext_space;
   logic [17:0] acc_addr = 0, ext_addr;
   // Outputs
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, acc_ready, acc_done, ext_strobe, ext_idle;
   logic ext_drive_enable, bus_hold_enable;
   logic [4:0] waits;
   int idles, failures = 0, checks = 0;
   localparam logic [11:0] WA = 12'h0a0, BA = 12'h0a4, MA = 12'h0ac;
   ebw_wait_bank u_dut (.*);
   ebw_ext_dev u_mem (.*);
   always #10 clock = ~clock;
   task automatic print_verdict;
      $display("Checks %0d, failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // A wait that ran out ends the run
   task automatic to(input int k);
      if (k >= 60) begin
         failures++;
         print_verdict;
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d,
      input logic [1:0] r = 2'h0);
      int k;
      logic ta, tw, tb;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      tb = 0;
      for (k = 0; k < 60 && !tb; k++) begin
         @(negedge clock);
         {ta, tw, tb} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
         if (tb) `CK(s_axi_bresp, r)
         @(posedge clock);
         if (ta) s_axi_awvalid <= 0;
         if (tw) s_axi_wvalid <= 0;
         if (tb) s_axi_bready <= 0;
      end
      to(k);
   endtask
   task automatic rd(input logic [11:0] a, input logic [15:0] e,
      input logic [1:0] r = 2'h0);
      int k;
      logic ta, tr;
      @(posedge clock);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      tr = 0;
      for (k = 0; k < 60 && !tr; k++) begin
         @(negedge clock);
         {ta, tr} = {s_axi_arready, s_axi_rvalid};
         if (tr) `CK({s_axi_rresp, s_axi_rdata}, {r, 16'h0, e})
         @(posedge clock);
         if (ta) s_axi_arvalid <= 0;
         if (tr) s_axi_rready <= 0;
      end
      to(k);
   endtask
   // One access; expect n wait cycles and g inserted idle cycles
   task automatic acc(input logic [1:0] s, input logic [17:0] a,
      input logic r, input int n, input int g);
      int k, i;
      @(posedge clock);
      i = idles;
      {acc_space, acc_addr, acc_read, acc_valid} <= {s, a, r, 1'h1};
      k = 0;
      do begin @(negedge clock); k++; end while (!acc_ready && k < 60);
      to(k);
      @(posedge clock);
      acc_valid <= 0;
      k = 0;
      do begin @(negedge clock); k++; end while (!acc_done && k < 60);
      to(k);
      @(posedge clock);
      #1;
      `CK(waits, n)
      `CK(idles - i, g)
      `CK({ext_space, ext_addr}, {s, a})
   endtask
   initial begin
      repeat (2) @(posedge clock);
      rst <= 0;
      rd(WA, 16'h7fff);
      rd(BA, 16'hf800);
      rd(MA, 16'h0000);
      acc(2'h0, 18'h00000, 0, 7, 0);
      wr(WA, 16'h58d6);
      acc(2'h2, 18'h00000, 0, 5, 0);
      acc(2'h1, 18'h08000, 0, 4, 0);
      acc(2'h1, 18'h00000, 0, 3, 1);
      acc(2'h1, 18'h00000, 0, 3, 0);
      acc(2'h0, 18'h08000, 0, 2, 0);
      acc(2'h0, 18'h00000, 0, 6, 1);
      acc(2'h0, 18'h10000, 0, 6, 1);
      acc(2'h1, 18'h00000, 0, 3, 1);
      wr(MA, 16'hffff);
      rd(MA, 16'h0001);
      acc(2'h1, 18'h00000, 0, 6, 0);
      wr(WA, 16'h7fff);
      acc(2'h2, 18'h00000, 0, 14, 0);
      wr(WA, 16'h0000);
      acc(2'h2, 18'h00000, 0, 1, 0);
      wr(WA, 16'h803a);
      acc(2'h0, 18'h18000, 0, 4, 0);
      wr(MA, 16'h0000);
      acc(2'h0, 18'h18000, 1, 2, 0);
      acc(2'h1, 18'h00000, 1, 1, 1);
      acc(2'h0, 18'h18000, 1, 2, 1);
      wr(BA, 16'hf000);
      acc(2'h1, 18'h00000, 1, 1, 1);
      acc(2'h0, 18'h18000, 1, 2, 0);
      wr(BA, 16'h0000);
      acc(2'h1, 18'h00000, 0, 1, 1);
      acc(2'h1, 18'h08000, 0, 1, 0);
      @(posedge clock) subsystem_select <= 1;
      repeat (3) @(posedge clock);
      acc(2'h1, 18'h08000, 0, 7, 0);
      @(posedge clock) subsystem_select <= 0;
      rd(12'h0b0, 16'h0000, 2'h2);
      wr(12'h0b0, 16'h1234, 2'h2);
      wr(BA, 16'h0005);
      repeat (3) @(negedge clock);
      `CK(acc_ready, 0)
      `CK(ext_drive_enable, 0)
      `CK(bus_hold_enable, 1)
      wr(BA, 16'h0000);
      @(negedge clock);
      `CK(ext_drive_enable, 1)
      `CK(bus_hold_enable, 0)
      print_verdict;
   end
endmodule
`default_nettype wire
